// ### rtl/csg_pkg.sv
// Package of constants and types for the configuration segment write guard
package csg_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Own register byte offsets on the APB slave
  localparam logic [11:0] OFS_KEY     = 12'h000; // Segment key register
  localparam logic [11:0] OFS_CFG     = 12'h004; // Segment lock config
  localparam logic [11:0] OFS_RSTSTAT = 12'h008; // Reset cause status one

  //////////////////////////////////////////////////////////////////////////
  // Key values
  localparam logic [7:0] KEY_ENABLE  = 8'hB5; // Opens the lock config
  localparam logic [7:0] KEY_DISABLE = 8'hB4; // Closes the lock config

  //////////////////////////////////////////////////////////////////////////
  // Field layout and reset values
  localparam int          NUM_SEG       = 4;     // Segments 0 to 3
  localparam int          SEGV_BIT      = 0;     // Violation flag position
  localparam logic [7:0]  CFG_RST       = 8'h00; // Lock config reset
  localparam logic [7:0]  KEY_RST       = 8'hB4; // Key register reset

  //////////////////////////////////////////////////////////////////////////
  // Segment address ranges on the guarded bus
  localparam logic [19:0] S0_RST_LO  = 20'h046F0; // Reset controls
  localparam logic [19:0] S0_RST_HI  = 20'h046F3;
  localparam logic [19:0] S0_TRIM_LO = 20'h04680; // Power trims
  localparam logic [19:0] S0_TRIM_HI = 20'h0468A;
  localparam logic [19:0] S0_ILO_LO  = 20'h04690; // Low speed oscillator
  localparam logic [19:0] S0_ILO_HI  = 20'h04691;
  localparam logic [19:0] S0_ILO_CR  = 20'h04300;
  localparam logic [19:0] S0_WDT     = 20'h04383; // Watchdog config
  localparam logic [19:0] S1_LVD_LO  = 20'h046F4; // Low voltage detect
  localparam logic [19:0] S1_LVD_HI  = 20'h046F6;
  localparam logic [19:0] S1_REG     = 20'h04331; // Regulators
  localparam logic [19:0] S1_PM_LO   = 20'h04380; // Power manager, wakeup
  localparam logic [19:0] S1_PM_HI   = 20'h04399;
  localparam logic [19:0] S1_BST_LO  = 20'h04320; // Boost converter
  localparam logic [19:0] S1_BST_HI  = 20'h04323;
  localparam logic [19:0] S1_FCK_LO  = 20'h04200; // Fast clock range
  localparam logic [19:0] S1_FCK_HI  = 20'h042FF;
  localparam logic [19:0] S1_IMO_LO  = 20'h046A0; // Main oscillator trims
  localparam logic [19:0] S1_IMO_HI  = 20'h046A7;
  localparam logic [19:0] S1_FLPM    = 20'h04801; // Flash low power
  localparam logic [19:0] S2_LO      = 20'h10000; // Logic array space
  localparam logic [19:0] S2_HI      = 20'h150FF;
  localparam logic [19:0] S3A_LO     = 20'h05800; // Analog interface
  localparam logic [19:0] S3A_HI     = 20'h05FFF;
  localparam logic [19:0] S3B_LO     = 20'h04600;
  localparam logic [19:0] S3B_HI     = 20'h0467F;

  //////////////////////////////////////////////////////////////////////////
  // Guard decision states
  typedef enum logic [1:0] {
    GRD_IDLE = 2'b01, // No guarded write pending
    GRD_HOLD = 2'b10  // Guarded write answered
  } csg_grd_t;

endpackage : csg_pkg

// ### rtl/csg_seg_decode.sv
// Segment decoder for guarded configuration bus addresses
`timescale 1ns/1ns
module csg_seg_decode (
  // Address in
  input  wire logic [19:0] addr_i,
  // One-hot segment hit out
  output logic      [3:0]  seg_hit_o
);

  // Inclusive range check
  function automatic logic in_rng(input logic [19:0] a,
                                  input logic [19:0] lo,
                                  input logic [19:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  // Map each address to the segment guarding it
  always_comb begin
    seg_hit_o    = 4'h0;
    seg_hit_o[0] = in_rng(addr_i, csg_pkg::S0_RST_LO, csg_pkg::S0_RST_HI)
                 | in_rng(addr_i, csg_pkg::S0_TRIM_LO, csg_pkg::S0_TRIM_HI)
                 | in_rng(addr_i, csg_pkg::S0_ILO_LO, csg_pkg::S0_ILO_HI)
                 | (addr_i == csg_pkg::S0_ILO_CR)
                 | (addr_i == csg_pkg::S0_WDT);
    seg_hit_o[1] = in_rng(addr_i, csg_pkg::S1_LVD_LO, csg_pkg::S1_LVD_HI)
                 | (addr_i == csg_pkg::S1_REG)
                 | (in_rng(addr_i, csg_pkg::S1_PM_LO, csg_pkg::S1_PM_HI)
                    && addr_i != csg_pkg::S0_WDT)
                 | in_rng(addr_i, csg_pkg::S1_BST_LO, csg_pkg::S1_BST_HI)
                 | in_rng(addr_i, csg_pkg::S1_FCK_LO, csg_pkg::S1_FCK_HI)
                 | in_rng(addr_i, csg_pkg::S1_IMO_LO, csg_pkg::S1_IMO_HI)
                 | (addr_i == csg_pkg::S1_FLPM);
    seg_hit_o[2] = in_rng(addr_i, csg_pkg::S2_LO, csg_pkg::S2_HI);
    seg_hit_o[3] = in_rng(addr_i, csg_pkg::S3A_LO, csg_pkg::S3A_HI)
                 | in_rng(addr_i, csg_pkg::S3B_LO, csg_pkg::S3B_HI);
  end

endmodule : csg_seg_decode

// ### rtl/csg_guard.sv
// Configuration segment write guard with APB register slave
`timescale 1ns/1ns
module csg_guard (
  // Clock and reset
  input  wire logic        clk_sys_i,    // System clock
  input  wire logic        rst_n_i,      // Device reset, sync, active low
  input  wire logic        por_n_i,      // Power-on reset, sync, active low
  // APB slave for own registers
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Guarded configuration bus write request
  input  wire logic        cfg_wr_req_i, // Write strobe, one cycle
  input  wire logic [19:0] cfg_wr_addr_i,
  // Guarded configuration bus write permission
  output logic             cfg_wr_ok_o,  // Pass write, one cycle
  output logic             cfg_wr_drop_o,// Dropped write, one cycle
  // Device reset request and state
  output logic             dev_rst_req_o,// Violation reset pulse
  output logic       [7:0] lock_cfg_o    // Current lock config
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic        key_open_r;     // Lock config writable
  logic  [7:0] key_last_r;     // Last legal key read back
  logic  [7:0] cfg_r;          // Lock and protect bits
  logic  [7:0] cfg_nxt;        // Next lock config
  logic        segv_r;         // Segment violation flag
  logic        rst_req_r;      // Violation reset request
  logic        ready_r;        // APB answer flop
  logic [31:0] rdata_r;        // APB read data flop
  logic        slverr_r;       // APB error flop
  logic        ok_r;           // Write pass flop
  logic        drop_r;         // Write drop flop
  logic  [3:0] seg_hit;        // Segment of guarded address
  logic  [3:0] seg_lock;       // Lock bit per segment
  logic        acc;            // APB access phase, one cycle
  logic        wr_acc;         // APB write access
  logic        key_wr;         // Write to key register
  logic        cfg_wr;         // Write to lock config
  logic        st_wr;          // Write to status
  logic        key_bad;        // Illegal key value
  logic        mapped;         // Address hits a register
  csg_pkg::csg_grd_t grd_r;    // Guard answer state

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; the slave answers one cycle into access
  assign acc    = psel_i & penable_i & ~ready_r;
  assign wr_acc = acc & pwrite_i;
  assign mapped = (paddr_i == csg_pkg::OFS_KEY) ||
                  (paddr_i == csg_pkg::OFS_CFG) ||
                  (paddr_i == csg_pkg::OFS_RSTSTAT);
  assign key_wr = wr_acc && (paddr_i == csg_pkg::OFS_KEY);
  assign cfg_wr = wr_acc && (paddr_i == csg_pkg::OFS_CFG);
  assign st_wr  = wr_acc && (paddr_i == csg_pkg::OFS_RSTSTAT);
  assign key_bad = key_wr && (pwdata_i[7:0] != csg_pkg::KEY_ENABLE) &&
                   (pwdata_i[7:0] != csg_pkg::KEY_DISABLE);

  ////////////////////////////////////////////////////////////////////////////
  // Segment decoder for the guarded bus
  csg_seg_decode u_dec (
    .addr_i    (cfg_wr_addr_i),
    .seg_hit_o (seg_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Lock bits of each segment at even positions
  genvar g;
  generate
    for (g = 0; g < csg_pkg::NUM_SEG; g++) begin : g_lock
      assign seg_lock[g] = cfg_r[2*g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next lock config: per-bit update honoring key and protect
  always_comb begin
    cfg_nxt = cfg_r;
    if (cfg_wr && key_open_r) begin
      for (int n = 0; n < csg_pkg::NUM_SEG; n++) begin
        // Lock bit writable only while unprotected
        if (!cfg_r[2*n+1]) begin
          cfg_nxt[2*n] = pwdata_i[2*n];
        end
        // Protect bit can only be set
        cfg_nxt[2*n+1] = cfg_r[2*n+1] | pwdata_i[2*n+1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key register state, relocked on every device reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !por_n_i) begin
      key_open_r <= 1'b0;
      key_last_r <= csg_pkg::KEY_RST;
    end else if (key_wr && !key_bad) begin
      key_open_r <= (pwdata_i[7:0] == csg_pkg::KEY_ENABLE);
      key_last_r <= pwdata_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock config; protect bits and their protected lock bits cleared only by a hardware reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !por_n_i) begin
      cfg_r <= csg_pkg::CFG_RST;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Violation flag: only power-on or software clears; set wins
  always_ff @(posedge clk_sys_i) begin
    if (!por_n_i) begin
      segv_r <= 1'b0;
    end else if (key_bad) begin
      segv_r <= 1'b1;
    end else if (st_wr && pwdata_i[csg_pkg::SEGV_BIT]) begin
      segv_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device reset request pulse on illegal key
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !por_n_i) begin
      rst_req_r <= 1'b0;
    end else begin
      rst_req_r <= key_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: ready one cycle into access, error on unmapped
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ready_r  <= 1'b0;
      slverr_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
    end else begin
      ready_r  <= acc;
      slverr_r <= acc && !mapped;
      rdata_r  <= 32'h0000_0000;
      if (acc && !pwrite_i) begin
        unique case (paddr_i)
          csg_pkg::OFS_KEY:     rdata_r <= {24'h000000, key_last_r};
          csg_pkg::OFS_CFG:     rdata_r <= {24'h000000, cfg_r};
          csg_pkg::OFS_RSTSTAT: rdata_r <= {31'h0, segv_r};
          default:              rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Guarded write decision, one cycle after the request
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !por_n_i) begin
      ok_r   <= 1'b0;
      drop_r <= 1'b0;
      grd_r  <= csg_pkg::GRD_IDLE;
    end else begin
      // Only lock bits matter; protect never blocks
      ok_r   <= cfg_wr_req_i && ((seg_hit & seg_lock) == 4'h0);
      drop_r <= cfg_wr_req_i && ((seg_hit & seg_lock) != 4'h0);
      unique case (grd_r)
        csg_pkg::GRD_IDLE: begin
          if (cfg_wr_req_i) begin
            grd_r <= csg_pkg::GRD_HOLD;
          end
        end
        csg_pkg::GRD_HOLD: begin
          if (!cfg_wr_req_i) begin
            grd_r <= csg_pkg::GRD_IDLE;
          end
        end
        default: grd_r <= csg_pkg::GRD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign prdata_o      = rdata_r;
  assign pready_o      = ready_r;
  assign pslverr_o     = slverr_r;
  assign cfg_wr_ok_o   = ok_r;
  assign cfg_wr_drop_o = drop_r;
  assign dev_rst_req_o = rst_req_r;
  assign lock_cfg_o    = cfg_r;

endmodule : csg_guard

// ### dv/csg_guard_props.sv
// Checker of guard answers, lock config bits and key handling
`timescale 1ns/1ns
module csg_guard_props (
  // Clock and resets
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        por_n_i,
  // APB side
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  // Guarded bus and state
  input wire logic        cfg_wr_req_i,
  input wire logic [19:0] cfg_wr_addr_i,
  input wire logic        cfg_wr_ok_o,
  input wire logic        cfg_wr_drop_o,
  input wire logic        dev_rst_req_o,
  input wire logic [7:0]  lock_cfg_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Access phase, logic array hit, illegal key write
  wire acc = psel_i && penable_i;
  wire in_s2 = cfg_wr_addr_i >= 20'h10000 && cfg_wr_addr_i <= 20'h150FF;
  wire key_wr = acc && pwrite_i && paddr_i == csg_pkg::OFS_KEY;
  wire bad_key = key_wr && pwdata_i[7:0] != 8'hB5 && pwdata_i[7:0] != 8'hB4;
  a_guard_answer: assert property (cfg_wr_req_i |=> cfg_wr_ok_o != cfg_wr_drop_o)
    else $error("guard answer not exactly one");
  a_guard_quiet: assert property (!cfg_wr_req_i |=> !cfg_wr_ok_o && !cfg_wr_drop_o)
    else $error("guard answered without request");
  a_locked_drop: assert property (cfg_wr_req_i && in_s2 && lock_cfg_o[4] |=> cfg_wr_drop_o)
    else $error("locked segment write passed");
  a_open_pass: assert property (cfg_wr_req_i && in_s2 && !lock_cfg_o[4] |=> cfg_wr_ok_o)
    else $error("unlocked segment write dropped");
  a_protect_sticky: assert property (por_n_i |=> (lock_cfg_o & $past(lock_cfg_o) & 8'hAA) == ($past(lock_cfg_o) & 8'hAA))
    else $error("protect bit cleared without reset");
  a_lock_frozen: assert property (por_n_i |=> ((lock_cfg_o ^ $past(lock_cfg_o)) & ($past(lock_cfg_o) >> 1) & 8'h55) == 8'h00)
    else $error("protected lock bit changed");
  a_bad_key_reset: assert property ($rose(acc) && bad_key |-> ##[1:2] dev_rst_req_o)
    else $error("illegal key gave no reset request");
  a_good_key_calm: assert property ($rose(acc) && key_wr && !bad_key |=> !dev_rst_req_o [*2])
    else $error("legal key gave reset request");
  a_ready_timing: assert property ($rose(acc) |=> pready_o)
    else $error("transfer not answered in time");
  // Main scenarios reached
  cover property ($rose(acc) && bad_key);
  cover property (cfg_wr_drop_o);
  cover property (cfg_wr_ok_o && lock_cfg_o != 8'h00);
endmodule : csg_guard_props

// ### dv/csg_guard_tb_top.sv
// Self-checking testbench of the configuration segment write guard
`timescale 1ns/1ns
module csg_guard_tb_top;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, por_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, slv, rst_seen = 1'b0, cfg_wr_req_i = 1'b0;
  logic [19:0] cfg_wr_addr_i = 20'h0;
  logic cfg_wr_ok_o, cfg_wr_drop_o, dev_rst_req_o;
  logic [7:0] lock_cfg_o;
  int errors = 0, samples_checked = 0;
  // Guarded addresses and the segment each belongs to, 4 is none
  logic [19:0] ga [14] = '{20'h046F0, 20'h0468A, 20'h04383, 20'h04300,
    20'h04200, 20'h046A7, 20'h04801, 20'h04399, 20'h10000, 20'h150FF,
    20'h05FFF, 20'h04600, 20'h15100, 20'h04700};
  int gs [14] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 3, 3, 4, 4};
  always #5 clk_sys_i = ~clk_sys_i;
  // Remember any reset request pulse
  always @(posedge clk_sys_i) if (dev_rst_req_o === 1'b1) rst_seen <= 1'b1;
  csg_guard i_dut (.*);
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // One APB transfer, waits for pready under a bound
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    for (n = 0; n < 20 && pready_o !== 1'b1; n++) @(posedge clk_sys_i);
    if (n == 20) begin
      errors++;
      complete_run();
    end
    rd = prdata_o;
    slv = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic reset_dut(logic por);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    por_n_i <= !por;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    por_n_i <= 1'b1;
  endtask : reset_dut
  // One guarded write, answer looked at in the following cycle
  task automatic guard(logic [19:0] a, logic drop);
    @(posedge clk_sys_i);
    cfg_wr_req_i <= 1'b1;
    cfg_wr_addr_i <= a;
    @(posedge clk_sys_i);
    cfg_wr_req_i <= 1'b0;
    #1;
    check("guard", {30'h0, cfg_wr_ok_o, cfg_wr_drop_o}, {30'h0, !drop, drop});
  endtask : guard
  task automatic s_reset_vals;
    apb(1'b0, csg_pkg::OFS_KEY, 32'h0);
    check("key", rd, 32'h0000_00B4);
    apb(1'b0, csg_pkg::OFS_CFG, 32'h0);
    check("cfg", rd, 32'h0);
  endtask : s_reset_vals
  // Lock config writes only between the two keys
  task automatic s_key_gate;
    apb(1'b1, csg_pkg::OFS_CFG, 32'hFF);
    apb(1'b0, csg_pkg::OFS_CFG, 32'h0);
    check("cfg closed", rd, 32'h0);
    apb(1'b1, csg_pkg::OFS_KEY, 32'hB5);
    apb(1'b1, csg_pkg::OFS_CFG, 32'h04);
    check("cfg seg1 lock", {24'h0, lock_cfg_o}, 32'h04);
    apb(1'b1, csg_pkg::OFS_KEY, 32'hB4);
    apb(1'b1, csg_pkg::OFS_CFG, 32'h00);
    apb(1'b0, csg_pkg::OFS_CFG, 32'h0);
    check("cfg relocked", rd, 32'h04);
  endtask : s_key_gate
  // Protect bits stick and freeze their lock bits
  task automatic s_protect;
    reset_dut(1'b1);
    apb(1'b1, csg_pkg::OFS_KEY, 32'hB5);
    apb(1'b1, csg_pkg::OFS_CFG, 32'h0C);
    apb(1'b1, csg_pkg::OFS_CFG, 32'h02);
    apb(1'b1, csg_pkg::OFS_CFG, 32'h03);
    apb(1'b0, csg_pkg::OFS_CFG, 32'h0);
    check("cfg protect", rd, 32'h0E);
    reset_dut(1'b0);
    check("cfg after reset", {24'h0, lock_cfg_o}, 32'h0);
    // Segment 0 handled as one-time setting: lock and protect together
    apb(1'b1, csg_pkg::OFS_KEY, 32'hB5);
    apb(1'b1, csg_pkg::OFS_CFG, 32'h03);
    check("seg0 one-time", {24'h0, lock_cfg_o}, 32'h03);
    apb(1'b1, csg_pkg::OFS_CFG, 32'h00);
    apb(1'b0, csg_pkg::OFS_CFG, 32'h0);
    check("seg0 frozen", rd, 32'h03);
  endtask : s_protect
  // Each segment locked alone, then protect bits alone
  task automatic s_guard;
    for (int n = 0; n < 5; n++) begin
      reset_dut(1'b1);
      apb(1'b1, csg_pkg::OFS_KEY, 32'hB5);
      apb(1'b1, csg_pkg::OFS_CFG, n < 4 ? 32'h1 << (2 * n) : 32'hAA);
      check("cfg", {24'h0, lock_cfg_o}, n < 4 ? 32'h1 << (2 * n) : 32'hAA);
      apb(1'b1, csg_pkg::OFS_KEY, 32'hB4);
      for (int i = 0; i < 14; i++) guard(ga[i], n < 4 && gs[i] == n);
    end
  endtask : s_guard
  // Illegal key, sticky cause flag, unmapped access
  task automatic s_violation;
    apb(1'b1, csg_pkg::OFS_KEY, 32'hB5);
    rst_seen <= 1'b0;
    apb(1'b1, csg_pkg::OFS_KEY, 32'h5A);
    repeat (2) @(posedge clk_sys_i);
    check("reset request", {31'h0, rst_seen}, 32'h1);
    reset_dut(1'b0);
    apb(1'b0, csg_pkg::OFS_RSTSTAT, 32'h0);
    check("cause flag", rd, 32'h1);
    apb(1'b0, csg_pkg::OFS_KEY, 32'h0);
    check("key", rd, 32'hB4);
    apb(1'b1, csg_pkg::OFS_RSTSTAT, 32'h1);
    apb(1'b0, csg_pkg::OFS_RSTSTAT, 32'h0);
    check("cause cleared", rd, 32'h0);
    apb(1'b1, csg_pkg::OFS_KEY, 32'h00);
    reset_dut(1'b1);
    apb(1'b0, csg_pkg::OFS_RSTSTAT, 32'h0);
    check("cause after por", rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    check("unmapped error", {31'h0, slv}, 32'h1);
  endtask : s_violation
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    por_n_i <= 1'b1;
    s_reset_vals();
    s_key_gate();
    s_protect();
    s_guard();
    s_violation();
    complete_run();
  end
endmodule : csg_guard_tb_top
bind csg_guard csg_guard_props u_props (.*);
